// [hw/cssp_consts.svh]
// Constants of the codec synchronous serial port: sizes, field widths and reset values.
`ifndef CSSP_CONSTS_SVH
`define CSSP_CONSTS_SVH

`define CSSP_MEM_ROWS      24
`define CSSP_ROW_AW        5
`define CSSP_CNT_W         6
`define CSSP_DEPTH_WIDE    6'h18
`define CSSP_DEPTH_NARROW  6'h30
`define CSSP_NARROW_MAXLEN 5'h0F
`define CSSP_WLEN_W        5
`define CSSP_WPF_W         4
`define CSSP_BYTE_W        8
`define CSSP_FRAME_RST     8'hFF
`define CSSP_STRAP_TAKE    2'h2
`define CSSP_STRAP_DONE    2'h3
`define CSSP_RX_MASK_BASE  32'hFFFF_FFFE
`define CSSP_HALF_ZERO     16'h0000
`define CSSP_WORD_ZERO     32'h0000_0000

`endif

// [hw/cssp_fifo.sv]
// Sample FIFO: 24 rows of 32 bits, used as 48 halfwords or 24 words.
`timescale 1ns/1ps
`default_nettype none
`include "cssp_consts.svh"

module cssp_fifo (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Mode
  input  wire logic        flush,
  input  wire logic        wide,
  // Fill side
  input  wire logic        pushValid,
  input  wire logic [31:0] pushData,
  output logic             pushReady,
  // Drain side
  output logic [31:0]      popData,
  output logic             popValid,
  input  wire logic        popReady,
  // Fill level
  output logic [5:0]       count
);
  import cssp_pkg::*;

  logic [31:0]                 mem [0:`CSSP_MEM_ROWS-1];
  logic [`CSSP_CNT_W-1:0]      wrPtr_r;
  logic [`CSSP_CNT_W-1:0]      rdPtr_r;
  logic [`CSSP_CNT_W-1:0]      count_r;
  logic [31:0]                 popData_r;
  logic                        popValid_r;
  wire  [`CSSP_CNT_W-1:0]      depth   = wide ? `CSSP_DEPTH_WIDE : `CSSP_DEPTH_NARROW;
  wire                         full    = (count_r == depth);
  wire                         doPush  = pushValid && !full;
  wire                         doPop   = popReady && popValid_r;
  wire  [`CSSP_ROW_AW-1:0]     wrRow   = wide ? wrPtr_r[4:0] : wrPtr_r[5:1];
  wire  [`CSSP_ROW_AW-1:0]     rdRow   = wide ? rdPtr_r[4:0] : rdPtr_r[5:1];
  wire  [`CSSP_CNT_W-1:0]      wrNext  = (wrPtr_r == depth - 6'h01) ? 6'h00 : wrPtr_r + 6'h01;
  wire  [`CSSP_CNT_W-1:0]      rdNext  = (rdPtr_r == depth - 6'h01) ? 6'h00 : rdPtr_r + 6'h01;
  wire  [31:0]                 rowData = mem[rdRow];
  wire  [15:0]                 rdHalf  = rdPtr_r[0] ? rowData[15:0] : rowData[31:16];

  assign pushReady = !full;
  assign popData   = popData_r;
  assign popValid  = popValid_r;
  assign count     = count_r;

  ////////////////////////////////////////////////////////////////////////////
  // Storage. A narrow entry fills one half; even entries take the upper half.
  always_ff @(posedge clk) begin
    if (doPush && wide) begin
      mem[wrRow] <= pushData;
    end else if (doPush && wrPtr_r[0]) begin
      mem[wrRow][15:0] <= pushData[15:0];
    end else if (doPush) begin
      mem[wrRow][31:16] <= pushData[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointers. Head data is re-read every cycle, so it is withheld for one
  // cycle after each pop while the new head settles.
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wrPtr_r    <= 6'h00;
      rdPtr_r    <= 6'h00;
      count_r    <= 6'h00;
      popValid_r <= 1'b0;
      popData_r  <= `CSSP_WORD_ZERO;
    end else begin
      if (doPush) begin
        wrPtr_r <= wrNext;
      end
      if (doPop) begin
        rdPtr_r <= rdNext;
      end
      count_r    <= count_r + {5'h00, doPush} - {5'h00, doPop};
      popValid_r <= (count_r != 6'h00) && !doPop;
      popData_r  <= wide ? rowData : {`CSSP_HALF_ZERO, rdHalf};
    end
  end

endmodule // cssp_fifo

`default_nettype wire

// [hw/cssp_pkg.sv]
// Types shared by the codec synchronous serial port.
package cssp_pkg;

  typedef enum logic [1:0] {
    CSSP_IDLE  = 2'b01,
    CSSP_SHIFT = 2'b10
  } cssp_state_t;

endpackage

// [hw/cssp_port.sv]
// Codec synchronous serial port: bit clock and frame generation, shifters and sample FIFOs.
`timescale 1ns/1ps
`default_nettype none
`include "cssp_consts.svh"

module cssp_port (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Configuration
  input  wire logic                    cfgMaster,
  input  wire logic                    cfgLoopback,
  input  wire logic                    cfgLongFrame,
  input  wire logic [4:0]              cfgWordLen,
  input  wire logic [3:0]              cfgWordsPerFrame,
  input  wire logic [7:0]              cfgBitsPerFrame,
  input  wire logic [7:0]              cfgClockDiv,
  input  wire logic [5:0]              cfgRxThreshold,
  input  wire logic [5:0]              cfgTxThreshold,
  input  wire logic                    cfgRxIrqEnable,
  input  wire logic                    cfgTxIrqEnable,
  // Strap and reference clock
  input  wire logic                    masterStrapInput,
  input  wire logic                    referenceClock,
  // Codec pins
  input  wire logic                    serialIn,
  output logic                         serialOut,
  input  wire logic                    bitClkIn,
  output logic                         bitClkOut,
  output logic                         bitClkOeN,
  input  wire logic                    frameSyncIn,
  output logic                         frameSyncOut,
  output logic                         frameSyncOeN,
  // Transmit FIFO fill
  input  wire logic [31:0]             txWrData,
  input  wire logic                    txWrValid,
  output logic                         txWrReady,
  // Receive FIFO drain
  output logic [31:0]                  rxRdData,
  output logic                         rxRdValid,
  input  wire logic                    rxRdReady,
  // Status
  output logic [5:0]                   txLevel,
  output logic [5:0]                   rxLevel,
  output logic                         txIrq,
  output logic                         rxIrq,
  output logic                         masterActive,
  output logic                         frameActive
);
  import cssp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and strap capture.
  logic [2:0]  refSync_r;
  logic [2:0]  sclkSync_r;
  logic [1:0]  syncInSync_r;
  logic [1:0]  sdiSync_r;
  logic [1:0]  strapSync_r;
  logic [1:0]  strapCnt_r;
  logic        strap_r;
  logic        master_r;
  logic        wide_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      refSync_r    <= 3'h0;
      sclkSync_r   <= 3'h0;
      syncInSync_r <= 2'h0;
      sdiSync_r    <= 2'h0;
      strapSync_r  <= 2'h0;
    end else begin
      refSync_r    <= {refSync_r[1:0], referenceClock};
      sclkSync_r   <= {sclkSync_r[1:0], bitClkIn};
      syncInSync_r <= {syncInSync_r[0], frameSyncIn};
      sdiSync_r    <= {sdiSync_r[0], serialIn};
      strapSync_r  <= {strapSync_r[0], masterStrapInput};
    end
  end

  // The strap is caught once, after it has passed both synchroniser stages.
  always_ff @(posedge clk) begin
    if (rst) begin
      strapCnt_r <= 2'h0;
      strap_r    <= 1'b0;
    end else if (strapCnt_r != `CSSP_STRAP_DONE) begin
      strapCnt_r <= strapCnt_r + 2'h1;
      if (strapCnt_r == `CSSP_STRAP_TAKE) begin
        strap_r <= strapSync_r[1];
      end
    end
  end

  // A mismatch between select bit and strap leaves the port a listener.
  wire masterNxt = cfgMaster && strap_r;
  wire wideNxt   = (cfgWordLen > `CSSP_NARROW_MAXLEN);
  wire fifoFlush = (wideNxt != wide_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      master_r <= 1'b0;
      wide_r   <= 1'b0;
    end else begin
      master_r <= masterNxt;
      wide_r   <= wideNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFOs.
  logic [31:0] txPopData;
  logic        txPopValid;
  logic        txPop;
  logic [31:0] rxPushData_r;
  logic        rxPush_r;
  logic        rxPushReady;

  cssp_fifo txFifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (fifoFlush),
    .wide      (wide_r),
    .pushValid (txWrValid),
    .pushData  (txWrData),
    .pushReady (txWrReady),
    .popData   (txPopData),
    .popValid  (txPopValid),
    .popReady  (txPop),
    .count     (txLevel)
  );

  cssp_fifo rxFifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (fifoFlush),
    .wide      (wide_r),
    .pushValid (rxPush_r),
    .pushData  (rxPushData_r),
    .pushReady (rxPushReady),
    .popData   (rxRdData),
    .popValid  (rxRdValid),
    .popReady  (rxRdReady),
    .count     (rxLevel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Master bit clock and frame pulse generation.
  logic [7:0]  divCnt_r;
  logic        sclkOut_r;
  logic [7:0]  frameBit_r;
  logic        syncOut_r;
  logic        txHeld_r;

  wire         refRise   = refSync_r[1] && !refSync_r[2];
  wire         divHit    = refRise && (divCnt_r == cfgClockDiv);
  wire         mRise     = master_r && divHit && !sclkOut_r;
  wire         mFall     = master_r && divHit && sclkOut_r;
  wire         frameWrap = (frameBit_r >= cfgBitsPerFrame);
  wire         txWaiting = txHeld_r || txPopValid;
  wire         withhold  = cfgLoopback && !txWaiting;
  wire         holdFrame = frameWrap && withhold;
  wire [7:0]   nextBit   = frameWrap ? 8'h00 : frameBit_r + 8'h01;
  wire         longSync  = ({3'h0, nextBit} <= {6'h00, cfgWordLen});
  wire         shortSync = (nextBit == cfgBitsPerFrame) && !withhold;
  wire         syncNxt   = cfgLongFrame ? longSync : shortSync;

  always_ff @(posedge clk) begin
    if (rst || !master_r) begin
      divCnt_r  <= 8'h00;
      sclkOut_r <= 1'b0;
    end else if (divHit) begin
      divCnt_r  <= 8'h00;
      sclkOut_r <= !sclkOut_r;
    end else if (refRise) begin
      divCnt_r  <= divCnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !master_r) begin
      frameBit_r <= `CSSP_FRAME_RST;
      syncOut_r  <= 1'b0;
    end else if (mRise && holdFrame) begin
      syncOut_r  <= 1'b0;
    end else if (mRise) begin
      frameBit_r <= nextBit;
      syncOut_r  <= syncNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Common bit events: generated in master mode, recovered in slave mode.
  wire sRise    = sclkSync_r[1] && !sclkSync_r[2];
  wire sFall    = !sclkSync_r[1] && sclkSync_r[2];
  wire bitRise  = master_r ? mRise : sRise;
  wire bitFall  = master_r ? mFall : sFall;
  wire syncSeen = master_r ? syncOut_r : syncInSync_r[1];

  logic        syncPrev_r;
  logic        shortArm_r;
  cssp_state_t state_r;
  cssp_state_t state_nxt;
  logic [4:0]  bitCnt_r;
  logic [3:0]  wordCnt_r;
  logic [31:0] rxSh_r;
  logic [31:0] txSh_r;
  logic        txLoad_r;
  logic        serialOut_r;

  wire isIdle    = (state_r == CSSP_IDLE);
  wire longStart = syncSeen && !syncPrev_r;
  wire startFall = bitFall && isIdle && (cfgLongFrame ? longStart : shortArm_r);
  wire sampleNow = bitFall && (!isIdle || startFall);
  wire dataIn    = cfgLoopback ? txSh_r[31] : sdiSync_r[1];
  wire [31:0] rxShNxt  = {rxSh_r[30:0], dataIn};
  wire [31:0] rxMask   = ~(`CSSP_RX_MASK_BASE << cfgWordLen);
  wire        lastBit  = (bitCnt_r == cfgWordLen);
  wire        lastWord = (wordCnt_r == cfgWordsPerFrame);
  wire        frameEnd = sampleNow && lastBit && lastWord;
  wire [31:0] txAlign  = wide_r ? txPopData : {txPopData[15:0], `CSSP_HALF_ZERO};
  wire        idleLoad = isIdle && !txHeld_r && txPopValid && !startFall;
  wire        riseLoad = bitRise && !isIdle && txLoad_r && txPopValid;

  assign txPop = idleLoad || riseLoad;

  always_ff @(posedge clk) begin
    if (rst) begin
      syncPrev_r <= 1'b0;
      shortArm_r <= 1'b0;
    end else if (bitFall) begin
      syncPrev_r <= syncSeen;
      shortArm_r <= syncSeen && !cfgLongFrame;
    end
  end

  always_comb begin
    case (state_r)
      CSSP_IDLE: begin
        state_nxt = startFall ? CSSP_SHIFT : CSSP_IDLE;
      end
      CSSP_SHIFT: begin
        state_nxt = frameEnd ? CSSP_IDLE : CSSP_SHIFT;
      end
      default: begin
        state_nxt = CSSP_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive side: sample on the falling edge, store right-justified.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r      <= CSSP_IDLE;
      bitCnt_r     <= 5'h00;
      wordCnt_r    <= 4'h0;
      rxSh_r       <= `CSSP_WORD_ZERO;
      rxPush_r     <= 1'b0;
      rxPushData_r <= `CSSP_WORD_ZERO;
    end else begin
      state_r  <= state_nxt;
      rxPush_r <= 1'b0;
      if (sampleNow) begin
        rxSh_r <= rxShNxt;
        if (lastBit) begin
          bitCnt_r     <= 5'h00;
          rxPush_r     <= 1'b1;
          rxPushData_r <= rxShNxt & rxMask;
          wordCnt_r    <= lastWord ? 4'h0 : wordCnt_r + 4'h1;
        end else begin
          bitCnt_r <= bitCnt_r + 5'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit side: the first word of a frame is preloaded while idle, so its
  // leading bit already stands on the line when the frame opens. A width change
  // drops the preloaded word too, since it belongs to the flushed FIFO.
  always_ff @(posedge clk) begin
    if (rst) begin
      txSh_r   <= `CSSP_WORD_ZERO;
      txHeld_r <= 1'b0;
      txLoad_r <= 1'b0;
    end else if (fifoFlush) begin
      txSh_r   <= `CSSP_WORD_ZERO;
      txHeld_r <= 1'b0;
      txLoad_r <= 1'b0;
    end else if (frameEnd) begin
      txSh_r   <= `CSSP_WORD_ZERO;
      txLoad_r <= 1'b0;
    end else if (startFall) begin
      txHeld_r <= 1'b0;
    end else if (idleLoad) begin
      txSh_r   <= txAlign;
      txHeld_r <= 1'b1;
    end else if (sampleNow && lastBit) begin
      txLoad_r <= 1'b1;
    end else if (bitRise && !isIdle && txLoad_r) begin
      txSh_r   <= riseLoad ? txAlign : `CSSP_WORD_ZERO;
      txLoad_r <= 1'b0;
    end else if (bitRise && !isIdle) begin
      txSh_r   <= {txSh_r[30:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and status.
  always_ff @(posedge clk) begin
    if (rst) begin
      serialOut_r <= 1'b0;
      txIrq       <= 1'b0;
      rxIrq       <= 1'b0;
    end else begin
      serialOut_r <= cfgLoopback ? 1'b0 : txSh_r[31];
      rxIrq       <= cfgRxIrqEnable && (rxLevel > cfgRxThreshold);
      txIrq       <= cfgTxIrqEnable && (txLevel < cfgTxThreshold);
    end
  end

  assign serialOut    = serialOut_r;
  assign bitClkOut    = sclkOut_r;
  assign bitClkOeN    = !master_r;
  assign frameSyncOut = syncOut_r;
  assign frameSyncOeN = !master_r;
  assign masterActive = master_r;
  assign frameActive  = !isIdle;

endmodule // cssp_port

`default_nettype wire

// [testbench/cssp_codec_model.sv]
// Behavioural codec that supplies bit clock, frame pulse and data in slave mode.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module cssp_codec_model (
  // Codec drive
  output logic      bitClk,
  output logic      frameSync,
  output logic      dataOut,
  // Port's serial output
  input  wire logic dataBack
);
  initial begin
    bitClk = 1'b0;
    frameSync = 1'b0;
    dataOut = 1'b0;
  end

  // One long-framed eight-bit word and two idle bits; the clock stands still between frames.
  task automatic frame(input logic [7:0] d, output logic [7:0] got);
    got = 8'h00;
    #3;
    for (int i = 0; i < 10; i++) begin
      bitClk = 1'b1;
      frameSync = (i < 8);
      dataOut = (i < 8) ? d[7 - i] : ~dataOut;
      #100;
      bitClk = 1'b0;
      if (i < 8) begin
        got[7 - i] = dataBack;
      end
      #100;
    end
    dataOut = ~dataOut;
  endtask
endmodule // cssp_codec_model
`default_nettype wire

// [testbench/cssp_props.sv]
// Concurrent checks on the ports of the codec serial port.
`timescale 1ns/1ps
`default_nettype none
`include "cssp_consts.svh"
////////////////////////////////////////////////////////////////////////////////
module cssp_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Configuration
  input wire logic        cfgMaster,
  input wire logic        cfgLoopback,
  input wire logic        cfgLongFrame,
  input wire logic [4:0]  cfgWordLen,
  input wire logic [5:0]  cfgRxThreshold,
  input wire logic [5:0]  cfgTxThreshold,
  input wire logic        cfgRxIrqEnable,
  input wire logic        cfgTxIrqEnable,
  // Pins and status
  input wire logic        serialOut,
  input wire logic        bitClkOeN,
  input wire logic        frameSyncOut,
  input wire logic        frameSyncOeN,
  input wire logic        txWrReady,
  input wire logic [31:0] rxRdData,
  input wire logic        rxRdValid,
  input wire logic [5:0]  txLevel,
  input wire logic [5:0]  rxLevel,
  input wire logic        txIrq,
  input wire logic        rxIrq,
  input wire logic        masterActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_pins_driven: assert property (masterActive && $past(masterActive) |-> !bitClkOeN && !frameSyncOeN)
    else $error("Master pins not driven");
  a_pins_released: assert property (!masterActive && !$past(masterActive) |-> bitClkOeN && frameSyncOeN)
    else $error("Slave pins driven");
  a_master_select: assert property (masterActive |-> $past(cfgMaster))
    else $error("Master without select bit");
  a_loop_low: assert property (cfgLoopback && $past(cfgLoopback) && $past(cfgLoopback, 2) |-> !serialOut)
    else $error("Output pin high in loopback");
  a_tx_irq: assert property (!$past(rst) |-> txIrq == $past(cfgTxIrqEnable && txLevel < cfgTxThreshold))
    else $error("Transmit interrupt wrong");
  a_rx_irq: assert property (!$past(rst) |-> rxIrq == $past(cfgRxIrqEnable && rxLevel > cfgRxThreshold))
    else $error("Receive interrupt wrong");
  a_full_narrow: assert property (cfgWordLen <= 5'h0F && txLevel == `CSSP_DEPTH_NARROW |-> !txWrReady)
    else $error("Narrow fifo overfilled");
  a_full_wide: assert property (cfgWordLen > 5'h0F && txLevel == `CSSP_DEPTH_WIDE |-> !txWrReady)
    else $error("Wide fifo overfilled");
  a_rx_zero: assert property (rxRdValid |-> (rxRdData >> ({1'b0, cfgWordLen} + 6'h01)) == 32'h0000_0000)
    else $error("Received word not zero filled");
  a_short_pulse: assert property (masterActive && !cfgLongFrame && $rose(frameSyncOut) |->
    frameSyncOut [*8] ##[8:14] !frameSyncOut)
    else $error("Short frame pulse not one bit long");
endmodule // cssp_props
`default_nettype wire

// [testbench/tb.sv]
// Self-checking testbench of the codec serial port.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module tb;
  logic        clk;
  logic        rst;
  logic        cfgMaster;
  logic        cfgLoopback;
  logic        cfgLongFrame;
  logic [4:0]  cfgWordLen;
  logic [3:0]  cfgWordsPerFrame;
  logic [7:0]  cfgBitsPerFrame;
  logic [7:0]  cfgClockDiv;
  logic [5:0]  cfgRxThreshold;
  logic [5:0]  cfgTxThreshold;
  logic        cfgRxIrqEnable;
  logic        cfgTxIrqEnable;
  logic        masterStrapInput;
  logic        referenceClock;
  logic [31:0] txWrData;
  logic        txWrValid;
  logic        rxRdReady;
  logic        serialOut;
  logic        bitClkOut;
  logic        bitClkOeN;
  logic        frameSyncOut;
  logic        frameSyncOeN;
  logic        txWrReady;
  logic [31:0] rxRdData;
  logic        rxRdValid;
  logic [5:0]  txLevel;
  logic [5:0]  rxLevel;
  logic        txIrq;
  logic        rxIrq;
  logic        masterActive;
  logic        frameActive;
  logic [7:0]  got;
  logic        clkPrev;
  int          edges;
  int          miscompares;
  int          comparisons;
  wire         modelClk;
  wire         modelSync;
  wire         serialIn;
  wire         bitClkIn;
  wire         frameSyncIn;

  // Each shared pin carries whichever party has its enable on.
  assign bitClkIn    = bitClkOeN ? modelClk : bitClkOut;
  assign frameSyncIn = frameSyncOeN ? modelSync : frameSyncOut;

  cssp_port dut_u (
    .clk, .rst, .cfgMaster, .cfgLoopback, .cfgLongFrame, .cfgWordLen, .cfgWordsPerFrame,
    .cfgBitsPerFrame, .cfgClockDiv, .cfgRxThreshold, .cfgTxThreshold, .cfgRxIrqEnable,
    .cfgTxIrqEnable, .masterStrapInput, .referenceClock, .serialIn, .serialOut, .bitClkIn,
    .bitClkOut, .bitClkOeN, .frameSyncIn, .frameSyncOut, .frameSyncOeN, .txWrData, .txWrValid,
    .txWrReady, .rxRdData, .rxRdValid, .rxRdReady, .txLevel, .rxLevel, .txIrq, .rxIrq,
    .masterActive, .frameActive
  );

  cssp_codec_model codec_u (
    .bitClk(modelClk), .frameSync(modelSync), .dataOut(serialIn), .dataBack(serialOut)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    referenceClock = 1'b0;
    forever #40 referenceClock = ~referenceClock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic fill(input int n, input logic [31:0] d);
    txWrValid <= 1'b1;
    txWrData <= d;
    repeat (n) @(posedge clk);
    txWrValid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic pop(input logic [31:0] exp);
    int n;
    n = 0;
    while (rxRdValid !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check(rxRdData, exp);
    rxRdReady <= 1'b1;
    @(posedge clk);
    rxRdReady <= 1'b0;
    @(posedge clk);
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    miscompares = 0;
    comparisons = 0;
    rst = 1'b1;
    txWrValid = 1'b0;
    txWrData = 32'h0000_0000;
    rxRdReady = 1'b0;
    cfgMaster = 1'b0;
    cfgLoopback = 1'b0;
    cfgLongFrame = 1'b1;
    cfgWordLen = 5'h07;
    cfgWordsPerFrame = 4'h0;
    cfgBitsPerFrame = 8'h0F;
    cfgClockDiv = 8'h00;
    cfgRxThreshold = 6'h00;
    cfgTxThreshold = 6'h04;
    cfgRxIrqEnable = 1'b1;
    cfgTxIrqEnable = 1'b1;
    masterStrapInput = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check(bitClkOeN, 1'b1);
    check(txWrReady, 1'b1);
    $display("Test reset done");
    fill(50, 32'h0000_1234);
    check(txLevel, 6'h30);
    check(txWrReady, 1'b0);
    check(txIrq, 1'b0);
    cfgWordLen <= 5'h1F;
    repeat (4) @(posedge clk);
    check(txLevel, 6'h00);
    check(txIrq, 1'b1);
    fill(26, 32'h8765_4321);
    check(txLevel, 6'h18);
    check(txWrReady, 1'b0);
    cfgTxThreshold <= 6'h19;
    repeat (3) @(posedge clk);
    check(txIrq, 1'b1);
    cfgWordLen <= 5'h07;
    repeat (4) @(posedge clk);
    check(txLevel, 6'h00);
    $display("Test fifo depth done");
    fill(1, 32'h0000_C300);
    codec_u.frame(8'h5A, got);
    check(got, 8'hC3);
    @(posedge clk);
    check(rxIrq, 1'b1);
    check(rxLevel, 6'h01);
    check(frameActive, 1'b0);
    pop(32'h0000_005A);
    codec_u.frame(8'h3C, got);
    check(got, 8'h00);
    pop(32'h0000_003C);
    $display("Test slave frames done");
    cfgMaster <= 1'b1;
    cfgLoopback <= 1'b1;
    cfgLongFrame <= 1'b0;
    repeat (4) @(posedge clk);
    check(masterActive, 1'b1);
    edges = 0;
    clkPrev = bitClkOut;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      check(frameSyncOut, 1'b0);
      edges += int'(bitClkOut != clkPrev);
      clkPrev = bitClkOut;
    end
    // Divider zero: one bit clock edge per reference period of ten clocks.
    check(edges, 32'h0000_0014);
    check(frameActive, 1'b0);
    fill(1, 32'h0000_A500);
    pop(32'h0000_00A5);
    $display("Test master loopback done");
    report_and_stop();
  end
endmodule // tb

bind cssp_port cssp_props props_u (
  .clk, .rst, .cfgMaster, .cfgLoopback, .cfgLongFrame, .cfgWordLen, .cfgRxThreshold,
  .cfgTxThreshold, .cfgRxIrqEnable, .cfgTxIrqEnable, .serialOut, .bitClkOeN, .frameSyncOut,
  .frameSyncOeN, .txWrReady, .rxRdData, .rxRdValid, .txLevel, .rxLevel, .txIrq, .rxIrq,
  .masterActive
);
`default_nettype wire
